// >>> design/dcr_crc_status.sv
// CRC result and status registers, byte-serial CRC engine, debug halt and
// memory priorities, behind an Avalon-MM slave with waitrequest.
// Assumes channel enables, data beats and the CPU halt indication come from logic on clk.
//
// Summary of operation
// RULE_01: Checksum register is 32 bits; upper 16 read zero with CRC-16.
// RULE_02: With CRC-16 and busy low, the checksum register holds the valid checksum.
// RULE_03: With CRC-32 and busy low, the checksum reads bit-reversed.
// RULE_04: Software reads the checksum only after busy has returned low.
// RULE_05: Selecting a new input source clears the zero-result flag.
// RULE_06: Zero-result flag sets when generation completes with a zero checksum.
// RULE_07: With I/O source, writing the data input register sets busy.
// RULE_08: With I/O source, writing one to busy clears it.
// RULE_09: With a channel source, busy clears when that channel is disabled.
// RULE_10: With a channel source, busy sets when that channel is enabled.
// RULE_11: Writing zero to busy does nothing; writing one does nothing for channels.
// RULE_12: Reserved bits read zero; software writes them as zero.
// RULE_13: Debug-run low halts the controller during CPU debug halt; high keeps running.
// RULE_14: Software reset leaves the debug-run bit unchanged.
// RULE_15: Bits 5:4 give the data transfer memory priority.
// RULE_16: Bits 3:2 give the descriptor fetch memory priority.
// RULE_17: Bits 1:0 give the write-back memory priority.
// RULE_18: Priority codes: 0 background, 1 bandwidth, 2 latency, 3 critical.
// RULE_19: Source codes: 0 none, 1 I/O, 0x20 up channel n; locked while busy.
// RULE_20: Polynomial codes: 0 CRC-16 CCITT, 1 CRC-32; others reserved.
// RULE_21: Each data write costs one clock cycle per byte of beat size.
// RULE_22: Write-back priority uses the same four-level encoding.
// RULE_23: While busy, new data accumulates into the running checksum.
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none

module dcr_crc_status #(
   parameter int NUM_CHANNELS = 32
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Avalon-MM register slave.
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Channel side: enables and data beats for the checksum.
   input wire logic [NUM_CHANNELS-1:0] channel_enabled,
   input wire logic beat_valid,
   input wire logic [31:0] beat_data,
   output logic beat_ready,
   // Debug halt.
   input wire logic cpu_debug_halted,
   output logic controller_halt,
   // Memory priorities.
   output dcr_pkg::dcr_qos_t memory_priority
);
   import dcr_pkg::*;

   // Register state.
   logic [5:0] crc_input_select;
   logic [1:0] polynomial_select;
   logic [1:0] beat_size;
   logic [31:0] crc_data_input;
   logic [31:0] crc_state;
   logic crc_busy_flag;
   logic zero_result_flag;
   logic run_in_debug;
   logic done_pending;
   logic channel_was_on;
   logic [31:0] shift_word;
   logic [2:0] bytes_left;

   // Combinational terms.
   logic [5:0] reg_index;
   logic wr_accept;
   logic data_stall;
   logic src_is_io;
   logic src_is_channel;
   logic [4:0] channel_number;
   logic channel_on;
   logic io_start;
   logic beat_take;
   logic start;
   logic [2:0] beat_cycles;
   logic is_crc32;
   logic [31:0] presented;
   logic soft_reset;
   logic busy_set;
   logic busy_clear;
   logic result_write;
   logic [31:0] next_crc_state;
   logic [31:0] next_shift_word;
   logic [2:0] next_bytes_left;
   logic [7:0] wdata_lane0;

   // Mirror a 32-bit word end for end.
   function automatic logic [31:0] reverse32(input logic [31:0] value);
      logic [31:0] out;
      out = 32'h0000_0000;
      for (int i = 0; i < 32; i++) begin
         out[i] = value[31-i];
      end
      return out;
   endfunction

   // Advance the checksum by one byte. CRC-16 takes data MSB first;
   // CRC-32 takes it LSB first, so the reflected result appears once mirrored.
   function automatic logic [31:0] crc_byte(input logic [31:0] state, input logic [7:0] data,
                                            input logic wide);
      logic [31:0] s;
      logic fb;
      s = state;
      fb = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (wide) begin
            fb = s[31] ^ data[i];
            s = {s[30:0], 1'b0} ^ (fb ? GEN_CRC32 : 32'h0000_0000);
         end else begin
            fb = s[15] ^ data[7-i];
            s = {16'h0000, s[14:0], 1'b0} ^ (fb ? {16'h0000, GEN_CRC16} : 32'h0000_0000);
         end
      end
      return s;
   endfunction

   // Bus decode and source decode.
   assign reg_index = avs_address[7:2];
   assign wr_accept = avs_write && !avs_waitrequest;
   assign wdata_lane0 = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
   assign src_is_io = (crc_input_select == SRC_IO); // RULE_19
   assign src_is_channel = (crc_input_select >= SRC_CHANNEL_BASE); // RULE_19
   assign channel_number = crc_input_select[4:0];
   assign channel_on = src_is_channel && (int'(channel_number) < NUM_CHANNELS)
                       && channel_enabled[channel_number];
   assign is_crc32 = (polynomial_select == POLY_CRC32); // RULE_20

   // A data write is held off while the engine still digests the previous beat.
   assign data_stall = avs_write && (reg_index == IDX_CRC_DATA_INPUT) && (bytes_left != 3'h0);

   // Software reset is refused while a checksum is in progress.
   assign soft_reset = wr_accept && (reg_index == IDX_ENGINE_CONTROL)
                       && wdata_lane0[SOFT_RESET_BIT] && !crc_busy_flag;

   // Checksum as software sees it.
   assign presented = is_crc32 ? reverse32(crc_state) // RULE_03
                               : {16'h0000, crc_state[15:0]}; // RULE_01 RULE_02

   // Beat size to engine cycles; the reserved code falls back to one byte.
   always_comb begin
      case (beat_size)
         BEAT_HWORD: beat_cycles = CYCLES_HWORD;
         BEAT_WORD: beat_cycles = CYCLES_WORD;
         default: beat_cycles = CYCLES_BYTE;
      endcase
   end

   // A new beat from either source starts only while not halted.
   assign io_start = wr_accept && (reg_index == IDX_CRC_DATA_INPUT) && src_is_io; // RULE_07
   assign beat_take = beat_valid && beat_ready;
   assign start = (io_start || beat_take) && !controller_halt;

   // Busy set and clear terms for both source kinds.
   assign busy_set = io_start // RULE_07
                     || (channel_on && !channel_was_on); // RULE_10
   assign busy_clear = (wr_accept && (reg_index == IDX_CRC_FLAGS) && src_is_io
                        && wdata_lane0[BUSY_BIT]) // RULE_08 RULE_11
                       || (src_is_channel && !channel_on && channel_was_on); // RULE_09

   // A checksum write seeds the engine, but only when it is idle.
   assign result_write = wr_accept && (reg_index == IDX_CRC_RESULT) && (bytes_left == 3'h0);

   // Engine next state: one byte per cycle, accumulating on the running checksum.
   always_comb begin
      next_crc_state = crc_state;
      next_shift_word = shift_word;
      next_bytes_left = bytes_left;
      if ((bytes_left != 3'h0) && !controller_halt) begin // RULE_13
         next_crc_state = crc_byte(crc_state, shift_word[7:0], is_crc32); // RULE_23
         next_shift_word = {8'h00, shift_word[31:8]};
         next_bytes_left = bytes_left - 3'h1; // RULE_21
      end else if (start) begin
         next_shift_word = io_start ? avs_writedata : beat_data;
         next_bytes_left = beat_cycles; // RULE_21
      end
      if (result_write) begin
         next_crc_state = is_crc32 ? reverse32(avs_writedata)
                                   : {16'h0000, avs_writedata[15:0]};
      end
   end

   // Engine registers.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         crc_state <= CRC_RESULT_RESET;
         shift_word <= CRC_DATA_RESET;
         bytes_left <= 3'h0;
      end else if (soft_reset) begin
         crc_state <= CRC_RESULT_RESET;
         shift_word <= CRC_DATA_RESET;
         bytes_left <= 3'h0;
      end else begin
         crc_state <= next_crc_state;
         shift_word <= next_shift_word;
         bytes_left <= next_bytes_left;
      end
   end

   // Offer channel beats while a channel source is busy and the engine is idle.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         beat_ready <= 1'b0;
      end else if (soft_reset) begin
         beat_ready <= 1'b0;
      end else begin
         beat_ready <= src_is_channel && crc_busy_flag && (next_bytes_left == 3'h0)
                       && !controller_halt && !start;
      end
   end

   // Configuration: source, polynomial and beat size. The source is frozen while busy.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         crc_input_select <= INPUT_SELECT_RESET;
         polynomial_select <= FIELD2_RESET;
         beat_size <= FIELD2_RESET;
      end else if (soft_reset) begin
         crc_input_select <= INPUT_SELECT_RESET;
         polynomial_select <= FIELD2_RESET;
         beat_size <= FIELD2_RESET;
      end else if (wr_accept && (reg_index == IDX_CRC_CONFIG)) begin
         if (avs_byteenable[1] && !crc_busy_flag) begin
            crc_input_select <= avs_writedata[INPUT_SELECT_LSB +: 6]; // RULE_19
         end
         if (avs_byteenable[0]) begin
            polynomial_select <= avs_writedata[POLY_SELECT_LSB +: 2];
            beat_size <= avs_writedata[BEAT_SIZE_LSB +: 2];
         end
      end
   end

   // Last word written to the data input register, kept for readback.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         crc_data_input <= CRC_DATA_RESET;
      end else if (soft_reset) begin
         crc_data_input <= CRC_DATA_RESET;
      end else if (wr_accept && (reg_index == IDX_CRC_DATA_INPUT)) begin
         crc_data_input <= avs_writedata;
      end
   end

   // Busy flag and channel enable history. Set wins if both arrive together.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         crc_busy_flag <= 1'b0;
         channel_was_on <= 1'b0;
      end else if (soft_reset) begin
         crc_busy_flag <= 1'b0;
         channel_was_on <= 1'b0;
      end else begin
         channel_was_on <= channel_on;
         if (busy_set) begin
            crc_busy_flag <= 1'b1; // RULE_07 RULE_10
         end else if (busy_clear) begin
            crc_busy_flag <= 1'b0; // RULE_08 RULE_09
         end
      end
   end

   // Once busy drops and the engine drains, judge the result.
   // A change of source clears the zero flag; a same-cycle set wins.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         done_pending <= 1'b0;
         zero_result_flag <= 1'b0;
      end else if (soft_reset) begin
         done_pending <= 1'b0;
         zero_result_flag <= 1'b0;
      end else begin
         if (crc_busy_flag && busy_clear && !busy_set) begin
            done_pending <= 1'b1;
         end else if (done_pending && (bytes_left == 3'h0)) begin
            done_pending <= 1'b0;
         end
         if (done_pending && (bytes_left == 3'h0) && (presented == 32'h0000_0000)) begin
            zero_result_flag <= 1'b1; // RULE_06
         end else if (wr_accept && (reg_index == IDX_CRC_CONFIG) && avs_byteenable[1]
                      && !crc_busy_flag
                      && (avs_writedata[INPUT_SELECT_LSB +: 6] != crc_input_select)) begin
            zero_result_flag <= 1'b0; // RULE_05
         end
      end
   end

   // Debug-run bit: the software reset leaves it alone.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         run_in_debug <= 1'b0;
      end else if (wr_accept && (reg_index == IDX_DEBUG_HALT_CONTROL) && avs_byteenable[0]) begin
         run_in_debug <= avs_writedata[RUN_IN_DEBUG_BIT]; // RULE_14
      end
   end

   // Halt request toward the rest of the controller; it also freezes the engine.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         controller_halt <= 1'b0;
      end else begin
         controller_halt <= cpu_debug_halted && !run_in_debug; // RULE_13
      end
   end

   // Priorities drive the arbiter straight from the register.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         memory_priority <= dcr_qos_t'(PRIORITY_RESET[5:0]);
      end else if (soft_reset) begin
         memory_priority <= dcr_qos_t'(PRIORITY_RESET[5:0]);
      end else if (wr_accept && (reg_index == IDX_MEMORY_PRIORITY_CONTROL)
                   && avs_byteenable[0]) begin
         memory_priority.transfer_priority <=
            dcr_priority_t'(avs_writedata[TRANSFER_PRI_LSB +: 2]); // RULE_15 RULE_18
         memory_priority.fetch_priority <=
            dcr_priority_t'(avs_writedata[FETCH_PRI_LSB +: 2]); // RULE_16 RULE_18
         memory_priority.writeback_priority <=
            dcr_priority_t'(avs_writedata[WRITEBACK_PRI_LSB +: 2]); // RULE_17 RULE_22
      end
   end

   // One wait state per access; waitrequest is low for one cycle.
   // Data writes also wait for the engine, which throttles software
   // to the engine rate without a buffer.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         avs_waitrequest <= 1'b1;
      end else if ((avs_read || avs_write) && avs_waitrequest && !data_stall) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // Read data is captured together with the drop of waitrequest.
   // Unmapped addresses and reserved bits read as zero.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && avs_waitrequest) begin
         case (reg_index)
            IDX_CRC_CONFIG: avs_readdata <= {16'h0000, 2'h0, crc_input_select, 4'h0,
                                             polynomial_select, beat_size}; // RULE_12
            IDX_CRC_DATA_INPUT: avs_readdata <= crc_data_input;
            IDX_CRC_RESULT: avs_readdata <= presented; // RULE_01 RULE_02 RULE_03
            IDX_CRC_FLAGS: avs_readdata <= {30'h0000_0000, zero_result_flag,
                                            crc_busy_flag}; // RULE_12
            IDX_DEBUG_HALT_CONTROL: avs_readdata <= {31'h0000_0000, run_in_debug};
            IDX_MEMORY_PRIORITY_CONTROL: avs_readdata <= {26'h000_0000, memory_priority};
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule

`default_nettype wire

// >>> design/dcr_pkg.sv
// Constants, field layouts and carrier types for the CRC result, status and QoS block.
// Assumes a single 250 MHz clock domain and an Avalon-MM register port with byte addressing.
package dcr_pkg;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [5:0] IDX_ENGINE_CONTROL = 6'h00;
   localparam logic [5:0] IDX_CRC_CONFIG = 6'h02;
   localparam logic [5:0] IDX_CRC_DATA_INPUT = 6'h04;
   localparam logic [5:0] IDX_CRC_RESULT = 6'h08;
   localparam logic [5:0] IDX_CRC_FLAGS = 6'h0C;
   localparam logic [5:0] IDX_DEBUG_HALT_CONTROL = 6'h0D;
   localparam logic [5:0] IDX_MEMORY_PRIORITY_CONTROL = 6'h0E;

   // Field positions.
   localparam int SOFT_RESET_BIT = 0;
   localparam int INPUT_SELECT_LSB = 8;
   localparam int POLY_SELECT_LSB = 2;
   localparam int BEAT_SIZE_LSB = 0;
   localparam int BUSY_BIT = 0;
   localparam int ZERO_BIT = 1;
   localparam int RUN_IN_DEBUG_BIT = 0;
   localparam int TRANSFER_PRI_LSB = 4;
   localparam int FETCH_PRI_LSB = 2;
   localparam int WRITEBACK_PRI_LSB = 0;

   // Values after reset.
   localparam logic [31:0] CRC_RESULT_RESET = 32'h0000_0000;
   localparam logic [31:0] CRC_DATA_RESET = 32'h0000_0000;
   localparam logic [5:0] INPUT_SELECT_RESET = 6'h00;
   localparam logic [1:0] FIELD2_RESET = 2'h0;
   localparam logic [7:0] PRIORITY_RESET = 8'h15;

   // Input source codes.
   localparam logic [5:0] SRC_NO_ACTION = 6'h00;
   localparam logic [5:0] SRC_IO = 6'h01;
   localparam logic [5:0] SRC_CHANNEL_BASE = 6'h20;

   // Polynomial selection and generator polynomials.
   localparam logic [1:0] POLY_CRC16 = 2'h0;
   localparam logic [1:0] POLY_CRC32 = 2'h1;
   localparam logic [15:0] GEN_CRC16 = 16'h1021;
   localparam logic [31:0] GEN_CRC32 = 32'h04C1_1DB7;

   // Beat sizes and the byte counts (one clock cycle each) they cost.
   localparam logic [1:0] BEAT_BYTE = 2'h0;
   localparam logic [1:0] BEAT_HWORD = 2'h1;
   localparam logic [1:0] BEAT_WORD = 2'h2;
   localparam logic [2:0] CYCLES_BYTE = 3'h1;
   localparam logic [2:0] CYCLES_HWORD = 3'h2;
   localparam logic [2:0] CYCLES_WORD = 3'h4;

   // Four memory access priority levels, lowest first.
   typedef enum logic [1:0] {
      DCR_PRI_BACKGROUND,
      DCR_PRI_BANDWIDTH,
      DCR_PRI_LATENCY,
      DCR_PRI_CRITICAL
   } dcr_priority_t;

   // Priorities handed to the memory arbiter.
   typedef struct packed {
      dcr_priority_t transfer_priority;
      dcr_priority_t fetch_priority;
      dcr_priority_t writeback_priority;
   } dcr_qos_t;

endpackage

// >>> verif/dcr_chk.sv
// Port assertions for the CRC result, status and priority block.
// Assumes soft reset is only requested while the engine is idle.
`timescale 1ns/1ns
`default_nettype none
module dcr_chk (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Register bus.
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Beats, halt and priorities.
   input wire logic beat_valid,
   input wire logic beat_ready,
   input wire logic cpu_debug_halted,
   input wire logic controller_halt,
   input wire dcr_pkg::dcr_qos_t memory_priority
);
   import dcr_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic wr_ok, rd_ok, run_q, halt_q;
   logic [1:0] poly_q, beat_q;
   logic [5:0] qos_q;
   assign wr_ok = avs_write && !avs_waitrequest;
   assign rd_ok = avs_read && !avs_waitrequest;
   // Shadow of the settings; run_q ignores soft reset on purpose.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         run_q <= 1'b0;
         halt_q <= 1'b0;
         poly_q <= 2'h0;
         beat_q <= 2'h0;
         qos_q <= 6'h15;
      end else begin
         halt_q <= cpu_debug_halted && !run_q;
         if (wr_ok && avs_address == 8'h34) run_q <= avs_writedata[0];
         if (wr_ok && avs_address == 8'h38) qos_q <= avs_writedata[5:0];
         if (wr_ok && avs_address == 8'h08) begin
            poly_q <= avs_writedata[3:2];
            beat_q <= avs_writedata[1:0];
         end
         if (wr_ok && avs_address == 8'h00 && avs_writedata[0]) begin
            poly_q <= 2'h0;
            beat_q <= 2'h0;
            qos_q <= 6'h15;
         end
      end
   end
   property p_halt;
      $past(rst_b) |-> controller_halt == halt_q;
   endproperty
   a_halt: assert property (p_halt) else $error("halt output wrong");
   property p_rst_qos;
      $rose(rst_b) |-> memory_priority == 6'h15;
   endproperty
   a_rst_qos: assert property (p_rst_qos) else $error("priority reset wrong");
   property p_qos_wr;
      wr_ok && avs_address == 8'h38 |-> ##[1:2] memory_priority == qos_q;
   endproperty
   a_qos_wr: assert property (p_qos_wr) else $error("priority not applied");
   property p_rsvd;
      rd_ok && avs_address[7:4] == 4'h3 |-> avs_readdata[31:6] == 26'h0;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
   property p_upper;
      rd_ok && avs_address == 8'h20 && poly_q != POLY_CRC32 |-> avs_readdata[31:16] == 16'h0;
   endproperty
   a_upper: assert property (p_upper) else $error("upper checksum not zero");
   property p_beat;
      beat_valid && beat_ready && beat_q == BEAT_WORD |=> !beat_ready [*4];
   endproperty
   a_beat: assert property (p_beat) else $error("word beat too short");
   property p_halt_rdy;
      controller_halt && $past(controller_halt) |-> !beat_ready;
   endproperty
   a_halt_rdy: assert property (p_halt_rdy) else $error("beat taken while halted");
   property p_answer;
      (avs_read || avs_write) && avs_waitrequest && avs_address[7:2] != IDX_CRC_DATA_INPUT
         |=> !avs_waitrequest;
   endproperty
   a_answer: assert property (p_answer) else $error("late bus answer");
   c_halt: cover property (controller_halt);
   c_beat: cover property (beat_valid && beat_ready);
   c_zero: cover property (rd_ok && avs_address == 8'h30 && avs_readdata[1]);
endmodule
bind dcr_crc_status dcr_chk i_dcr_chk (.clk, .rst_b, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_readdata, .avs_waitrequest, .beat_valid, .beat_ready,
   .cpu_debug_halted, .controller_halt, .memory_priority);
`default_nettype wire

// >>> verif/dcr_chan_model.sv
// Behavioural DMA channels that enable themselves and offer data beats.
// Assumes the bench calls its tasks in sequence, with a gap of at least one cycle.
`timescale 1ns/1ns
`default_nettype none
module dcr_chan_model #(
   parameter int NUM_CHANNELS = 32
) (
   // Clock.
   input wire logic clk,
   // Channel side of the block.
   output logic [NUM_CHANNELS-1:0] channel_enabled,
   output logic beat_valid,
   output logic [31:0] beat_data,
   input wire logic beat_ready
);
   // Idle lines at time zero.
   initial begin
      channel_enabled = '0;
      beat_valid = 1'b0;
      beat_data = 32'h0;
   end
   // Change one enable just after an edge.
   task automatic set_chan(input int n, input logic on);
      @(posedge clk);
      channel_enabled[n] <= on;
   endtask
   // Hold a beat until taken; then show the inverse so stale data never looks fresh.
   task automatic send(input logic [31:0] d, input int gap);
      int k;
      repeat (gap) @(posedge clk);
      beat_valid <= 1'b1;
      beat_data <= d;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (beat_ready !== 1'b1 && k < 200);
      beat_valid <= 1'b0;
      beat_data <= ~d;
   endtask
endmodule
`default_nettype wire

// >>> verif/dcr_crc_status_test.sv
// Self-checking bench for the CRC result, status and priority block.
// Assumes the design's package and the channel model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module dcr_crc_status_test;
   import dcr_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} dcr_row_t;
   logic clk, rst_b, avs_read, avs_write, avs_waitrequest;
   logic beat_valid, beat_ready, cpu_debug_halted, controller_halt;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, beat_data, channel_enabled;
   dcr_qos_t memory_priority;
   int n_fail = 0;
   int n_compared = 0;
   dcr_row_t rows[12] = '{'{8'h38, 32'h00, 32'h00}, '{8'h38, 32'h15, 32'h15},
      '{8'h38, 32'h2A, 32'h2A}, '{8'h38, 32'h3F, 32'h3F}, '{8'h38, 32'h1B, 32'h1B},
      '{8'h34, 32'h00, 32'h00}, '{8'h34, 32'h01, 32'h01}, '{8'h3C, 32'hFF, 32'h00},
      '{8'h20, 32'h1234_5678, 32'h0000_5678}, '{8'h30, 32'h00, 32'h00},
      '{8'h08, 32'h2507, 32'h2507}, '{8'h08, 32'h00, 32'h00}};
   dcr_crc_status i_dcr_crc_status (.clk, .rst_b, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
      .channel_enabled, .beat_valid, .beat_data, .beat_ready, .cpu_debug_halted,
      .controller_halt, .memory_priority);
   dcr_chan_model i_dcr_chan_model (.clk, .channel_enabled, .beat_valid, .beat_data,
      .beat_ready);
   // Free-running clock.
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Compare and count.
   task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
      end
   endtask
   // One Avalon transfer, held until waitrequest is sampled low.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int k;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 100);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e, input string w);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(w, q, e);
   endtask
   // Reference checksum in read form; CRC-32 runs reflected.
   function automatic logic [31:0] ref_crc(input logic [31:0] c, input logic [31:0] s,
                                           input logic [31:0] d);
      int n;
      logic [31:0] p;
      n = c[1:0] == BEAT_WORD ? 4 : c[1:0] == BEAT_HWORD ? 2 : 1;
      p = {<<{GEN_CRC32}};
      if (c[3:2] != POLY_CRC32) s = {16'h0, s[15:0]};
      for (int i = 0; i < n; i++) begin
         for (int j = 0; j < 8; j++) begin
            if (c[3:2] == POLY_CRC32) begin
               if (j == 0) s = s ^ 32'(d[8*i+:8]);
               s = s[0] ? (s >> 1) ^ p : s >> 1;
            end else begin
               if (j == 0) s[15:8] = s[15:8] ^ d[8*i+:8];
               s = {16'h0, s[14:0], 1'b0} ^ (s[15] ? 32'(GEN_CRC16) : 32'h0);
            end
         end
      end
      return s;
   endfunction
   // Two back-to-back data writes over the I/O source, then release busy.
   task automatic io_crc(input logic [31:0] c, input logic [31:0] s, input logic [31:0] d);
      logic [31:0] e;
      e = ref_crc(c, ref_crc(c, s, d), d);
      wr(8'h08, c);
      wr(8'h20, s);
      wr(8'h10, d);
      wr(8'h10, d);
      rc(8'h30, 32'h1, "busy io");
      wr(8'h30, 32'h0);
      rc(8'h30, 32'h1, "busy w0");
      wr(8'h30, 32'h1);
      rc(8'h20, e, "checksum");
      rc(8'h30, {30'h0, e == 32'h0, 1'b0}, "flags io");
   endtask
   task automatic summarize();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Watchdog well beyond the few hundred cycles the tests need.
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      summarize();
   end
   // Main sequence.
   initial begin
      {rst_b, avs_read, avs_write, cpu_debug_halted} = 4'h0;
      avs_address = 8'h00;
      avs_writedata = 32'h0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rc(rows[i].a, rows[i].e, "row");
         if (rows[i].a == 8'h38) check("prio", 32'(memory_priority), rows[i].e);
      end
      wr(8'h00, 32'h1);
      rc(8'h34, 32'h1, "run kept");
      rc(8'h38, 32'h15, "prio soft");
      io_crc(32'h0100, 32'hFFFF, 32'h31);
      io_crc(32'h0101, 32'h1D0F, 32'hA55A);
      io_crc(32'h0106, 32'hFFFF_FFFF, 32'h3132_3334);
      io_crc(32'h0106, 32'h0, 32'h0);
      wr(8'h08, 32'h2306);
      rc(8'h30, 32'h0, "zero cleared");
      wr(8'h20, 32'hFFFF_FFFF);
      i_dcr_chan_model.set_chan(3, 1'b1);
      rc(8'h30, 32'h1, "busy chan");
      wr(8'h30, 32'h1);
      rc(8'h30, 32'h1, "busy w1 chan");
      wr(8'h08, 32'h0106);
      rc(8'h08, 32'h2306, "source lock");
      i_dcr_chan_model.send(32'hDEAD_BEEF, 1);
      i_dcr_chan_model.send(32'h0123_4567, 5);
      i_dcr_chan_model.set_chan(3, 1'b0);
      rc(8'h30, 32'h0, "busy off");
      rc(8'h20, ref_crc(32'h6, ref_crc(32'h6, '1, 32'hDEAD_BEEF), 32'h0123_4567), "chan sum");
      wr(8'h34, 32'h0);
      cpu_debug_halted <= 1'b1;
      rc(8'h34, 32'h0, "run off");
      check("halted", 32'(controller_halt), 32'h1);
      wr(8'h34, 32'h1);
      rc(8'h34, 32'h1, "run on");
      check("running", 32'(controller_halt), 32'h0);
      cpu_debug_halted <= 1'b0;
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rc(8'h34, 32'h0, "run reset");
      rc(8'h20, 32'h0, "sum reset");
      rc(8'h38, 32'h15, "prio reset");
      summarize();
   end
endmodule
`default_nettype wire
